/* File: design/hsp_sequencer.sv */
// Contract
// - Main power only while all supplies valid and slot request active.
// - Request comes from pin in direct mode, serial enable command otherwise.
// - Twelve-volt and main-rail gate ramps start in the same cycle.
// - Persistent over-current latches slot off until request removed and reapplied.
// - Under-voltage comparators armed only when both gate-good indications true.
// - Armed persistent under-voltage latches slot off until request cycled.
// - I/O gate rises with power enable, falls after main gate below 1 V.
// - Event switch closes after aux good, opens at once on fault or switch open.
// - Aux output off and bled low on aux fault or open switch.
// - Mode sampled on rising edge of system power good.
//
// The address map and the AXI4-Lite register port were decided locally.
`timescale 1ns/100ps
module hsp_sequencer #(
  parameter logic [hsp_pkg::CNT_W-1:0] OC_SENSE_CYCLES = hsp_pkg::OC_SENSE_CYCLES,
  parameter logic [hsp_pkg::CNT_W-1:0] UV_SENSE_CYCLES = hsp_pkg::UV_SENSE_CYCLES
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Register bus
  input wire logic [hsp_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [hsp_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Pins, asynchronous to aclk
  input wire hsp_pkg::hsp_pins_type pins,
  // Main and I/O gate drives, under-voltage comparator enables
  output logic [hsp_pkg::SLOTS-1:0] gate_ramp_twelve_volt,
  output logic [hsp_pkg::SLOTS-1:0] gate_ramp_main_rails,
  output logic [hsp_pkg::SLOTS-1:0] uv_comparator_enable,
  output logic io_voltage_gate_slot_a,
  output logic io_voltage_gate_slot_b,
  // Auxiliary rails and event bus
  output logic slot_a_aux_rail_out,
  output logic slot_b_aux_rail_out,
  output logic [hsp_pkg::SLOTS-1:0] aux_bleed,
  output logic slot_a_event_bus_out,
  output logic slot_b_event_bus_out,
  // Interrupt
  output logic irq
);

  hsp_pkg::hsp_state_type r;
  hsp_pkg::hsp_state_type next_r;

  always_comb begin
    logic do_write;
    logic do_read;
    logic req;
    logic granted;
    logic oc_trip;
    logic uv_trip;
    logic aux_ok;
    logic [hsp_pkg::IRQ_W-1:0] events;
    logic [hsp_pkg::IRQ_W-1:0] clear;
    do_write = 1'b0;
    do_read = 1'b0;
    req = 1'b0;
    granted = 1'b0;
    oc_trip = 1'b0;
    uv_trip = 1'b0;
    aux_ok = 1'b0;
    events = '0;
    clear = '0;
    next_r = r;

    // Two-flop synchroniser; only the second stage is read below
    next_r.pins_meta = pins;
    next_r.pins_sync = r.pins_meta;
    next_r.system_power_good_in_prev = r.pins_sync.system_power_good_in;

    if (r.pins_sync.system_power_good_in && !r.system_power_good_in_prev) begin
      next_r.mode_serial = r.pins_sync.mode_select_serial;
    end

    // Write channel: address and data taken in either order
    if (s_axi_awvalid && s_axi_awready) begin
      next_r.aw_held = 1'b1;
      next_r.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_r.w_held = 1'b1;
      next_r.wdata = s_axi_wdata;
      next_r.wstrb = s_axi_wstrb;
    end
    if (r.bvalid && s_axi_bready) begin
      next_r.bvalid = 1'b0;
    end
    do_write = r.aw_held && r.w_held && !r.bvalid;
    if (do_write) begin
      next_r.aw_held = 1'b0;
      next_r.w_held = 1'b0;
      next_r.bvalid = 1'b1;
      next_r.bresp = hsp_pkg::RESP_OKAY;
      if (r.awaddr == hsp_pkg::ADDR_CTRL) begin
        if (r.wstrb[0]) begin
          next_r.serial_power_enable = r.wdata[hsp_pkg::SLOTS-1:0];
        end
      end else if (r.awaddr == hsp_pkg::ADDR_STATUS) begin
        next_r.bresp = hsp_pkg::RESP_OKAY;
      end else if (r.awaddr == hsp_pkg::ADDR_IRQ_STATUS) begin
        if (r.wstrb[0]) begin
          clear = r.wdata[hsp_pkg::IRQ_W-1:0];
        end
      end else if (r.awaddr == hsp_pkg::ADDR_IRQ_MASK) begin
        if (r.wstrb[0]) begin
          next_r.irq_mask = r.wdata[hsp_pkg::IRQ_W-1:0];
        end
      end else begin
        next_r.bresp = hsp_pkg::RESP_SLVERR;
      end
    end

    // Read channel: one outstanding read, answered the cycle after arready
    if (r.rvalid && s_axi_rready) begin
      next_r.rvalid = 1'b0;
    end
    do_read = s_axi_arvalid && !r.rvalid;
    if (do_read) begin
      next_r.rvalid = 1'b1;
      next_r.rresp = hsp_pkg::RESP_OKAY;
      next_r.rdata = '0;
      if (s_axi_araddr == hsp_pkg::ADDR_CTRL) begin
        next_r.rdata = 32'(r.serial_power_enable);
      end else if (s_axi_araddr == hsp_pkg::ADDR_STATUS) begin
        for (int i = 0; i < hsp_pkg::SLOTS; i++) begin
          next_r.rdata[hsp_pkg::STAT_POWERED_LSB + i] =
            (r.slot[i].state == hsp_pkg::SLOT_RAMP) || (r.slot[i].state == hsp_pkg::SLOT_ON);
          next_r.rdata[hsp_pkg::STAT_LATCHED_LSB + i] =
            (r.slot[i].state == hsp_pkg::SLOT_LATCHED);
          next_r.rdata[hsp_pkg::STAT_UV_ARMED_LSB + i] = (r.slot[i].state == hsp_pkg::SLOT_ON);
          next_r.rdata[hsp_pkg::STAT_EVENT_CONN_LSB + i] = r.slot[i].event_conn;
        end
        next_r.rdata[hsp_pkg::STAT_MODE_SERIAL_BIT] = r.mode_serial;
      end else if (s_axi_araddr == hsp_pkg::ADDR_IRQ_STATUS) begin
        next_r.rdata = 32'(r.irq_status);
      end else if (s_axi_araddr == hsp_pkg::ADDR_IRQ_MASK) begin
        next_r.rdata = 32'(r.irq_mask);
      end else begin
        next_r.rresp = hsp_pkg::RESP_SLVERR;
      end
    end

    for (int i = 0; i < hsp_pkg::SLOTS; i++) begin
      req = r.mode_serial ? r.serial_power_enable[i] : r.pins_sync.slot_power_request[i];
      granted = req && r.pins_sync.supplies_valid;

      oc_trip = 1'b0;
      if (r.pins_sync.over_current[i] &&
          (r.slot[i].state == hsp_pkg::SLOT_RAMP || r.slot[i].state == hsp_pkg::SLOT_ON)) begin
        if (r.slot[i].oc_cnt >= OC_SENSE_CYCLES) begin
          oc_trip = 1'b1;
        end else begin
          next_r.slot[i].oc_cnt = r.slot[i].oc_cnt + 1'b1;
        end
      end else begin
        next_r.slot[i].oc_cnt = '0;
      end

      uv_trip = 1'b0;
      if (r.pins_sync.under_voltage[i] && r.slot[i].state == hsp_pkg::SLOT_ON) begin
        if (r.slot[i].uv_cnt >= UV_SENSE_CYCLES) begin
          uv_trip = 1'b1;
        end else begin
          next_r.slot[i].uv_cnt = r.slot[i].uv_cnt + 1'b1;
        end
      end else begin
        next_r.slot[i].uv_cnt = '0;
      end

      case (r.slot[i].state)
        hsp_pkg::SLOT_OFF: begin
          if (granted) begin
            next_r.slot[i].state = hsp_pkg::SLOT_RAMP;
            next_r.slot[i].io_gate = 1'b1;
          end
        end
        hsp_pkg::SLOT_RAMP: begin
          if (oc_trip) begin
            next_r.slot[i].state = hsp_pkg::SLOT_LATCHED;
            events[hsp_pkg::IRQ_OVER_CURRENT_LSB + i] = 1'b1;
          end else if (!granted) begin
            next_r.slot[i].state = hsp_pkg::SLOT_OFF;
          end else if (r.pins_sync.gate_good_twelve[i] && r.pins_sync.gate_good_main[i]) begin
            next_r.slot[i].state = hsp_pkg::SLOT_ON;
          end
        end
        hsp_pkg::SLOT_ON: begin
          if (oc_trip || uv_trip) begin
            next_r.slot[i].state = hsp_pkg::SLOT_LATCHED;
            events[hsp_pkg::IRQ_OVER_CURRENT_LSB + i] = oc_trip;
            events[hsp_pkg::IRQ_UNDER_VOLTAGE_LSB + i] = uv_trip;
          end else if (!granted) begin
            next_r.slot[i].state = hsp_pkg::SLOT_OFF;
          end
        end
        default: begin
          if (!req) begin
            next_r.slot[i].state = hsp_pkg::SLOT_OFF;
          end
        end
      endcase

      // gate falls only once main gate is low
      if ((r.slot[i].state == hsp_pkg::SLOT_OFF || r.slot[i].state == hsp_pkg::SLOT_LATCHED)
          && r.pins_sync.main_gate_below_1v[i] && !(granted && r.slot[i].state == hsp_pkg::SLOT_OFF)) begin
        next_r.slot[i].io_gate = 1'b0;
      end

      // aux fault held until switch opens
      if (!r.pins_sync.aux_switch_closed[i]) begin
        next_r.slot[i].aux_fault = 1'b0;
      end else if (r.pins_sync.aux_over_current[i] && r.slot[i].aux_on) begin
        next_r.slot[i].aux_fault = 1'b1;
        events[hsp_pkg::IRQ_AUX_FAULT_LSB + i] = 1'b1;
      end
      aux_ok = r.pins_sync.aux_switch_closed[i] && !r.slot[i].aux_fault &&
               !r.pins_sync.aux_over_current[i];
      next_r.slot[i].aux_on = aux_ok;
      next_r.slot[i].event_conn = aux_ok && (r.slot[i].event_conn ||
                                             r.pins_sync.aux_voltage_good[i]);
      // Open switch leaves the line released, seen high through the pull-up
      next_r.slot[i].event_low = next_r.slot[i].event_conn && !r.pins_sync.event_in[i];
    end

    // New events win over a same-cycle clear
    next_r.irq_status = (r.irq_status & ~clear) | events;
    next_r.irq = |(next_r.irq_status & next_r.irq_mask);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      r <= hsp_pkg::STATE_RESET;
    end else begin
      r <= next_r;
    end
  end

  always_comb begin
    s_axi_awready = !r.aw_held;
    s_axi_wready = !r.w_held;
    s_axi_bvalid = r.bvalid;
    s_axi_bresp = r.bresp;
    s_axi_arready = !r.rvalid;
    s_axi_rvalid = r.rvalid;
    s_axi_rdata = r.rdata;
    s_axi_rresp = r.rresp;
    for (int i = 0; i < hsp_pkg::SLOTS; i++) begin
      gate_ramp_twelve_volt[i] =
        (r.slot[i].state == hsp_pkg::SLOT_RAMP) || (r.slot[i].state == hsp_pkg::SLOT_ON);
      gate_ramp_main_rails[i] = gate_ramp_twelve_volt[i];
      uv_comparator_enable[i] = (r.slot[i].state == hsp_pkg::SLOT_ON);
      aux_bleed[i] = !r.slot[i].aux_on;
    end
    io_voltage_gate_slot_a = r.slot[0].io_gate;
    io_voltage_gate_slot_b = r.slot[1].io_gate;
    slot_a_aux_rail_out = r.slot[0].aux_on;
    slot_b_aux_rail_out = r.slot[1].aux_on;
    slot_a_event_bus_out = !r.slot[0].event_low;
    slot_b_event_bus_out = !r.slot[1].event_low;
    irq = r.irq;
  end

endmodule : hsp_sequencer

/* File: design/hsp_pkg.sv */
package hsp_pkg;

  localparam int SLOTS = 2;
  localparam int ADDR_W = 4;
  localparam int CNT_W = 16;

  // Register byte offsets
  localparam logic [3:0] ADDR_CTRL = 4'h0;
  localparam logic [3:0] ADDR_STATUS = 4'h4;
  localparam logic [3:0] ADDR_IRQ_STATUS = 4'h8;
  localparam logic [3:0] ADDR_IRQ_MASK = 4'hC;

  // Status word field positions
  localparam int STAT_POWERED_LSB = 0;
  localparam int STAT_LATCHED_LSB = 2;
  localparam int STAT_UV_ARMED_LSB = 4;
  localparam int STAT_EVENT_CONN_LSB = 6;
  localparam int STAT_MODE_SERIAL_BIT = 8;

  // Interrupt status and mask field positions
  localparam int IRQ_W = 6;
  localparam int IRQ_OVER_CURRENT_LSB = 0;
  localparam int IRQ_UNDER_VOLTAGE_LSB = 2;
  localparam int IRQ_AUX_FAULT_LSB = 4;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Timing
  localparam int CLK_PERIOD_NS = 5;
  localparam int OC_SENSE_TIME_NS = 1000;
  localparam int UV_SENSE_TIME_NS = 2000;
  localparam logic [CNT_W-1:0] OC_SENSE_CYCLES =
    CNT_W'((OC_SENSE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] UV_SENSE_CYCLES =
    CNT_W'((UV_SENSE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  typedef enum logic [1:0] {
    SLOT_OFF = 2'h0,
    SLOT_RAMP = 2'h1,
    SLOT_ON = 2'h3,
    SLOT_LATCHED = 2'h2
  } hsp_slot_state_type;

  // Everything arriving from pins, synchronised as one group
  typedef struct packed {
    logic system_power_good_in;
    logic mode_select_serial;
    logic supplies_valid;
    logic [SLOTS-1:0] slot_power_request;
    logic [SLOTS-1:0] over_current;
    logic [SLOTS-1:0] under_voltage;
    logic [SLOTS-1:0] gate_good_twelve;
    logic [SLOTS-1:0] gate_good_main;
    logic [SLOTS-1:0] main_gate_below_1v;
    logic [SLOTS-1:0] aux_voltage_good;
    logic [SLOTS-1:0] aux_over_current;
    logic [SLOTS-1:0] aux_switch_closed;
    logic [SLOTS-1:0] event_in;
  } hsp_pins_type;

  typedef struct packed {
    hsp_slot_state_type state;
    logic [CNT_W-1:0] oc_cnt;
    logic [CNT_W-1:0] uv_cnt;
    logic io_gate;
    logic aux_fault;
    logic aux_on;
    logic event_conn;
    logic event_low;
  } hsp_slot_type;

  typedef struct packed {
    hsp_pins_type pins_meta;
    hsp_pins_type pins_sync;
    logic system_power_good_in_prev;
    logic mode_serial;
    hsp_slot_type [SLOTS-1:0] slot;
    logic [SLOTS-1:0] serial_power_enable;
    logic [IRQ_W-1:0] irq_status;
    logic [IRQ_W-1:0] irq_mask;
    logic irq;
    logic aw_held;
    logic [ADDR_W-1:0] awaddr;
    logic w_held;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } hsp_state_type;

  localparam hsp_state_type STATE_RESET = '0;

endpackage : hsp_pkg

/* File: tb/hsp_slot_model.sv */
`timescale 1ns/100ps
module hsp_slot_model (
  // Clock
  input wire logic aclk,
  // Response delay in cycles, small is prompt
  input wire logic [7:0] dly,
  // Drives from the sequencer
  input wire logic [1:0] ramp,
  input wire logic [1:0] aux_on,
  // Indications back to the sequencer
  output logic [1:0] gate_good,
  output logic [1:0] below_1v,
  output logic [1:0] aux_good
);
  // Gates charge and discharge slowly, so goods lag the drive
  logic [7:0] up [2] = '{8'h00, 8'h00};
  logic [7:0] dn [2] = '{8'h00, 8'h00};
  always_ff @(posedge aclk) begin
    for (int i = 0; i < 2; i++) begin
      up[i] <= ramp[i] ? up[i] + 8'(up[i] != 8'hFF) : 8'h00;
      dn[i] <= ramp[i] ? 8'h00 : dn[i] + 8'(dn[i] != 8'hFF);
      gate_good[i] <= ramp[i] && up[i] >= dly;
      below_1v[i] <= !ramp[i] && dn[i] >= dly;
      aux_good[i] <= aux_on[i];
    end
  end
endmodule : hsp_slot_model

/* File: tb/hsp_sequencer_chk.sv */
`timescale 1ns/100ps
module hsp_sequencer_chk #(
  parameter logic [hsp_pkg::CNT_W-1:0] OC_SENSE_CYCLES = hsp_pkg::OC_SENSE_CYCLES,
  parameter logic [hsp_pkg::CNT_W-1:0] UV_SENSE_CYCLES = hsp_pkg::UV_SENSE_CYCLES
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Watched ports
  input wire hsp_pkg::hsp_pins_type pins,
  input wire logic [hsp_pkg::SLOTS-1:0] gate_ramp_twelve_volt,
  input wire logic [hsp_pkg::SLOTS-1:0] gate_ramp_main_rails,
  input wire logic [hsp_pkg::SLOTS-1:0] uv_comparator_enable,
  input wire logic io_voltage_gate_slot_a,
  input wire logic slot_a_aux_rail_out,
  input wire logic [hsp_pkg::SLOTS-1:0] aux_bleed,
  input wire logic slot_a_event_bus_out
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Run lengths at the pins; slack of 6 covers synchroniser delay
  logic [hsp_pkg::CNT_W-1:0] oc_run;
  logic [hsp_pkg::CNT_W-1:0] uv_run;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      oc_run <= '0;
      uv_run <= '0;
    end else begin
      oc_run <= pins.over_current[0] ? oc_run + 1'b1 : '0;
      uv_run <= (pins.under_voltage[0] && (uv_run != '0 || uv_comparator_enable[0])) ?
        uv_run + 1'b1 : '0;
    end
  end
  AST_RAMPS_TOGETHER:
    assert property (gate_ramp_twelve_volt == gate_ramp_main_rails)
    else $error("gate ramps apart");
  AST_SUPPLY_GATE:
    assert property ($rose(gate_ramp_main_rails[0]) |-> $past(pins.supplies_valid, 3))
    else $error("ramp without valid supplies");
  AST_UV_ARM_CAUSE:
    assert property ($rose(uv_comparator_enable[0]) |->
      $past(pins.gate_good_twelve[0] && pins.gate_good_main[0], 3))
    else $error("comparators armed early");
  AST_OC_TRIP:
    assert property (oc_run >= OC_SENSE_CYCLES + 6 |-> !gate_ramp_main_rails[0])
    else $error("over-current not latched");
  AST_UV_TRIP:
    assert property (uv_run >= UV_SENSE_CYCLES + 6 |-> !gate_ramp_main_rails[0])
    else $error("under-voltage not latched");
  AST_IO_FALL:
    assert property ($fell(io_voltage_gate_slot_a) |->
      !gate_ramp_main_rails[0] && $past(pins.main_gate_below_1v[0], 3))
    else $error("io gate fell early");
  AST_AUX_OPEN:
    assert property (!pins.aux_switch_closed[0] [*3] |=> !slot_a_aux_rail_out && aux_bleed[0])
    else $error("aux rail not bled");
  AST_EVENT_OPEN:
    assert property (!pins.aux_switch_closed[0] [*4] |=> slot_a_event_bus_out)
    else $error("event switch still closed");
endmodule : hsp_sequencer_chk

bind hsp_sequencer hsp_sequencer_chk #(
  .OC_SENSE_CYCLES(OC_SENSE_CYCLES),
  .UV_SENSE_CYCLES(UV_SENSE_CYCLES)
) u_chk (.aclk, .aresetn, .pins, .gate_ramp_twelve_volt, .gate_ramp_main_rails,
  .uv_comparator_enable, .io_voltage_gate_slot_a, .slot_a_aux_rail_out, .aux_bleed,
  .slot_a_event_bus_out);

/* File: tb/hot_plug_slot_power_sequencer_bench.sv */
`timescale 1ns/100ps
module hot_plug_slot_power_sequencer_bench;
  localparam int OC = 4;
  localparam int UV = 6;
  logic aclk;
  logic aresetn = 1'b0;
  logic [3:0] s_axi_awaddr = 4'h0;
  logic [3:0] s_axi_araddr = 4'h0;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'h0;
  logic s_axi_awvalid = 1'b0;
  logic s_axi_wvalid = 1'b0;
  logic s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
  logic [1:0] s_axi_bresp, s_axi_rresp, gg, b1, ag;
  logic [31:0] s_axi_rdata;
  hsp_pkg::hsp_pins_type drv = '0;
  hsp_pkg::hsp_pins_type pins;
  logic [1:0] gate_ramp_twelve_volt, gate_ramp_main_rails, uv_comparator_enable, aux_bleed;
  logic io_voltage_gate_slot_a, io_voltage_gate_slot_b, slot_a_aux_rail_out;
  logic slot_b_aux_rail_out, slot_a_event_bus_out, slot_b_event_bus_out;
  logic [7:0] dly = 8'h0A;
  int n_mismatch = 0;
  int cmp_count = 0;
  logic [1:0] bresp_seen = 2'h0;

  always_comb begin
    pins = drv;
    pins.gate_good_twelve = gg;
    pins.gate_good_main = gg;
    pins.main_gate_below_1v = b1;
    pins.aux_voltage_good = ag;
  end

  hsp_sequencer #(.OC_SENSE_CYCLES(16'(OC)), .UV_SENSE_CYCLES(16'(UV))) u_dut (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .pins, .gate_ramp_twelve_volt, .gate_ramp_main_rails,
    .uv_comparator_enable, .io_voltage_gate_slot_a, .io_voltage_gate_slot_b,
    .slot_a_aux_rail_out, .slot_b_aux_rail_out, .aux_bleed, .slot_a_event_bus_out,
    .slot_b_event_bus_out, .irq);

  hsp_slot_model u_slots (.aclk, .dly, .ramp(gate_ramp_main_rails),
    .aux_on({slot_b_aux_rail_out, slot_a_aux_rail_out}), .gate_good(gg), .below_1v(b1),
    .aux_good(ag));

  initial begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end

  task automatic cyc(input int n);
    repeat (n) @(posedge aclk);
  endtask : cyc

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected %s: expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'hF;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    bresp_seen = s_axi_bresp;
    s_axi_bready <= 1'b0;
    @(posedge aclk);
  endtask : wr

  task automatic rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
    @(posedge aclk);
  endtask : rd

  task automatic rchk(input logic [3:0] a, input logic [31:0] exp);
    logic [31:0] d;
    logic [1:0] r;
    rd(a, d, r);
    chk("reg", d, exp);
  endtask : rchk

  task automatic final_report;
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : final_report

  // Whole sequence needs under a thousand cycles
  initial begin
    cyc(4000);
    n_mismatch++;
    final_report();
  end

  initial begin
    logic [31:0] d;
    logic [1:0] r;
    drv.event_in <= 2'h3;
    cyc(10);
    aresetn <= 1'b1;
    cyc(1);
    chk("bleed", 32'(aux_bleed), 32'h3);
    chk("event", 32'({slot_b_event_bus_out, slot_a_event_bus_out}), 32'h3);
    for (int i = 0; i < 4; i++) begin
      rchk(4'(4 * i), 32'h0);
    end
    rd(4'h2, d, r);
    chk("resp", 32'(r), 32'(hsp_pkg::RESP_SLVERR));
    wr(4'h2, 32'h3F);
    chk("bresp", 32'(bresp_seen), 32'(hsp_pkg::RESP_SLVERR));
    wr(hsp_pkg::ADDR_IRQ_MASK, 32'h3F);
    chk("bresp", 32'(bresp_seen), 32'(hsp_pkg::RESP_OKAY));
    rchk(hsp_pkg::ADDR_IRQ_MASK, 32'h3F);
    drv.slot_power_request[0] <= 1'b1;
    cyc(8);
    chk("ramp", 32'(gate_ramp_main_rails), 32'h0);
    drv.supplies_valid <= 1'b1;
    cyc(4);
    chk("ramp12", 32'(gate_ramp_twelve_volt), 32'h1);
    chk("io", 32'(io_voltage_gate_slot_a), 32'h1);
    cyc(20);
    chk("uv", 32'(uv_comparator_enable), 32'h1);
    drv.over_current[0] <= 1'b1;
    cyc(OC);
    drv.over_current[0] <= 1'b0;
    cyc(8);
    chk("ramp", 32'(gate_ramp_main_rails), 32'h1);
    drv.over_current[0] <= 1'b1;
    cyc(OC + 8);
    drv.over_current[0] <= 1'b0;
    chk("ramp", 32'(gate_ramp_main_rails), 32'h0);
    chk("io", 32'(io_voltage_gate_slot_a), 32'h1);
    chk("irq", 32'(irq), 32'h1);
    rchk(hsp_pkg::ADDR_IRQ_STATUS, 32'h1);
    wr(hsp_pkg::ADDR_IRQ_STATUS, 32'h1);
    cyc(20);
    chk("irq", 32'(irq), 32'h0);
    chk("io", 32'(io_voltage_gate_slot_a), 32'h0);
    chk("ramp", 32'(gate_ramp_main_rails), 32'h0);
    drv.slot_power_request[0] <= 1'b0;
    cyc(6);
    dly <= 8'h28;
    drv.slot_power_request[0] <= 1'b1;
    drv.under_voltage[0] <= 1'b1;
    cyc(20);
    chk("ramp", 32'(gate_ramp_main_rails), 32'h1);
    chk("uv", 32'(uv_comparator_enable), 32'h0);
    drv.under_voltage[0] <= 1'b0;
    cyc(36);
    chk("uv", 32'(uv_comparator_enable), 32'h1);
    drv.under_voltage[0] <= 1'b1;
    cyc(UV + 8);
    chk("ramp", 32'(gate_ramp_main_rails), 32'h0);
    rchk(hsp_pkg::ADDR_IRQ_STATUS, 32'h4);
    wr(hsp_pkg::ADDR_IRQ_MASK, 32'h3B);
    cyc(2);
    chk("irq", 32'(irq), 32'h0);
    drv.under_voltage[0] <= 1'b0;
    drv.slot_power_request[0] <= 1'b0;
    dly <= 8'h0A;
    drv.mode_select_serial <= 1'b1;
    cyc(4);
    drv.system_power_good_in <= 1'b1;
    cyc(6);
    drv.mode_select_serial <= 1'b0;
    drv.slot_power_request[0] <= 1'b1;
    wr(hsp_pkg::ADDR_CTRL, 32'h2);
    cyc(24);
    chk("ramp", 32'(gate_ramp_main_rails), 32'h2);
    chk("io b", 32'(io_voltage_gate_slot_b), 32'h1);
    rchk(hsp_pkg::ADDR_STATUS, 32'h122);
    wr(hsp_pkg::ADDR_CTRL, 32'h0);
    cyc(6);
    chk("ramp", 32'(gate_ramp_main_rails), 32'h0);
    drv.event_in[0] <= 1'b0;
    drv.aux_switch_closed[0] <= 1'b1;
    cyc(10);
    chk("aux", 32'(slot_a_aux_rail_out), 32'h1);
    chk("event", 32'(slot_a_event_bus_out), 32'h0);
    drv.aux_over_current[0] <= 1'b1;
    cyc(5);
    drv.aux_over_current[0] <= 1'b0;
    chk("bleed", 32'(aux_bleed), 32'h3);
    chk("event", 32'(slot_a_event_bus_out), 32'h1);
    rchk(hsp_pkg::ADDR_IRQ_STATUS, 32'h14);
    chk("irq", 32'(irq), 32'h1);
    chk("aux", 32'(slot_a_aux_rail_out), 32'h0);
    drv.aux_switch_closed[0] <= 1'b0;
    cyc(6);
    drv.aux_switch_closed[0] <= 1'b1;
    cyc(10);
    chk("event", 32'(slot_a_event_bus_out), 32'h0);
    drv.aux_switch_closed[0] <= 1'b0;
    cyc(5);
    chk("aux", 32'(slot_a_aux_rail_out), 32'h0);
    chk("event", 32'(slot_a_event_bus_out), 32'h1);
    chk("aux b", 32'(slot_b_aux_rail_out), 32'h0);
    chk("event b", 32'(slot_b_event_bus_out), 32'h1);
    final_report();
  end
endmodule : hot_plug_slot_power_sequencer_bench
